// File: inc/vps_pkg.sv
`default_nettype none

package vps_pkg;

    localparam int          VPS_AW              = 8;
    localparam int          VPS_DW              = 32;
    localparam int          VPS_VW              = 16;

    // register byte offsets
    localparam logic [7:0]  VPS_REG_CTRL        = 8'h00;
    localparam logic [7:0]  VPS_REG_OV_CFG      = 8'h04;
    localparam logic [7:0]  VPS_REG_UV_CFG      = 8'h08;
    localparam logic [7:0]  VPS_REG_ROV_CFG     = 8'h0C;
    localparam logic [7:0]  VPS_REG_OV_DELAY    = 8'h10;
    localparam logic [7:0]  VPS_REG_UV_DELAY    = 8'h14;
    localparam logic [7:0]  VPS_REG_ROV_DELAY   = 8'h18;
    localparam logic [7:0]  VPS_REG_STATUS      = 8'h1C;

    // control field positions
    localparam int          VPS_CTRL_OV_ON      = 0;
    localparam int          VPS_CTRL_ROV_ON     = 1;
    localparam int          VPS_CTRL_UV_MODE    = 2;
    localparam int          VPS_CTRL_OV_SO      = 4;
    localparam int          VPS_CTRL_UV_SO      = 5;
    localparam int          VPS_CTRL_ROV_SO     = 6;

    // stage config field positions
    localparam int          VPS_CFG_PICK        = 0;
    localparam int          VPS_CFG_RR          = 8;
    localparam int          VPS_CFG_BLK         = 16;

    // values after reset, percent of nominal or ms
    localparam logic [7:0]  VPS_OV_PICK_RST     = 8'h3F;
    localparam logic [7:0]  VPS_UV_PICK_RST     = 8'h5A;
    localparam logic [7:0]  VPS_ROV_PICK_RST    = 8'h1E;
    localparam logic [3:0]  VPS_RR_RST          = 4'h5;
    localparam logic [4:0]  VPS_UV_BLK_RST      = 5'h0A;
    localparam logic [15:0] VPS_DELAY_RST       = 16'h0064;

    // voltages arrive in hundredths of a percent of nominal
    localparam logic [7:0]  VPS_PCT_UNIT        = 8'h64;

    typedef enum logic [1:0] {
        VPS_UV_OFF  = 2'h0,
        VPS_UV_1OF3 = 2'h1,
        VPS_UV_2OF3 = 2'h2,
        VPS_UV_ALL  = 2'h3
    } vps_uv_mode_e;

    // millisecond tick
    localparam int          VPS_CLK_PERIOD_NS   = 20;
    localparam int          VPS_TICK_PERIOD_US  = 1000;
    localparam int          VPS_TICK_CYCLES     = VPS_TICK_PERIOD_US * 1000 / VPS_CLK_PERIOD_NS;

endpackage

`default_nettype wire

// File: core/vps_tick.sv
`timescale 1ns/1ps
`default_nettype none

module vps_tick
    import vps_pkg::*;
#(
    parameter int TICK_CYCLES = VPS_TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } vps_tick_s;

    localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);

    vps_tick_s s_r;
    vps_tick_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt >= LAST) begin
            s_nxt.cnt  = 16'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_tick_gap: assert property (tick && (TICK_CYCLES > 1) |=> !tick)
        else $error("tick pulses back to back");

endmodule

`default_nettype wire

// File: core/vps_delay.sv
`timescale 1ns/1ps
`default_nettype none

module vps_delay
    import vps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        tick,
    input  wire logic        start,
    input  wire logic        start_only,
    input  wire logic [15:0] delay,
    output logic             trip
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        trip;
    } vps_delay_s;

    vps_delay_s s_r;
    vps_delay_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!start) begin
            s_nxt.cnt  = 16'h0000;
            s_nxt.trip = 1'b0;
        end else begin
            // start only still counts, so clearing it late trips at once
            s_nxt.trip = !start_only && (s_r.cnt >= delay);
            if (tick && (s_r.cnt < delay)) begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trip = s_r.trip;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_elapsed;
        start && !start_only && (s_r.cnt >= delay);
    endsequence

    a_trip_cause: assert property (trip |-> $past(start) && !$past(start_only))
        else $error("trip without start or with start only");
    a_trip_after: assert property (s_elapsed |=> trip)
        else $error("trip missing after delay elapsed");
    a_trip_clear: assert property (!start |=> !trip && (s_r.cnt == 16'h0000))
        else $error("trip or count kept after start ended");

endmodule

`default_nettype wire

// File: core/vps_top.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module vps_top
    import vps_pkg::*;
#(
    parameter int TICK_CYCLES = VPS_TICK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [VPS_AW-1:0] reg_addr,
    input  wire logic [VPS_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [VPS_DW-1:0] reg_rdata,
    input  wire logic [VPS_VW-1:0] phase_voltage_a,
    input  wire logic [VPS_VW-1:0] phase_voltage_b,
    input  wire logic [VPS_VW-1:0] phase_voltage_c,
    input  wire logic [VPS_VW-1:0] residual_voltage_magnitude,
    output logic      [2:0]        ov_start,
    output logic                   ov_start_any,
    output logic                   ov_trip,
    output logic      [2:0]        uv_start,
    output logic                   uv_start_any,
    output logic                   uv_trip,
    output logic                   res_ov_start,
    output logic                   res_ov_trip
);

    typedef struct packed {
        logic         ov_on;
        logic         rov_on;
        vps_uv_mode_e uv_mode;
        logic         ov_so;
        logic         uv_so;
        logic         rov_so;
        logic [7:0]   ov_pick;
        logic [7:0]   uv_pick;
        logic [7:0]   rov_pick;
        logic [3:0]   ov_rr;
        logic [3:0]   uv_rr;
        logic [3:0]   rov_rr;
        logic [4:0]   uv_blk;
        logic [15:0]  ov_dly;
        logic [15:0]  uv_dly;
        logic [15:0]  rov_dly;
        logic [2:0]   ov_st;
        logic [2:0]   uv_st;
        logic         ov_any;
        logic         uv_any;
        logic         rov_st;
        logic [31:0]  rdata;
    } vps_top_s;

    localparam vps_top_s RST = '{
        ov_on:    1'b1,
        rov_on:   1'b1,
        uv_mode:  VPS_UV_1OF3,
        ov_so:    1'b0,
        uv_so:    1'b0,
        rov_so:   1'b0,
        ov_pick:  VPS_OV_PICK_RST,
        uv_pick:  VPS_UV_PICK_RST,
        rov_pick: VPS_ROV_PICK_RST,
        ov_rr:    VPS_RR_RST,
        uv_rr:    VPS_RR_RST,
        rov_rr:   VPS_RR_RST,
        uv_blk:   VPS_UV_BLK_RST,
        ov_dly:   VPS_DELAY_RST,
        uv_dly:   VPS_DELAY_RST,
        rov_dly:  VPS_DELAY_RST,
        ov_st:    3'h0,
        uv_st:    3'h0,
        ov_any:   1'b0,
        uv_any:   1'b0,
        rov_st:   1'b0,
        rdata:    32'h0000_0000
    };

    vps_top_s               s_r;
    vps_top_s               s_nxt;
    logic [2:0][VPS_VW-1:0] v_ph;
    logic [2:0]             trip_vec;
    logic [2:0]             arm_vec;
    logic [2:0]             so_vec;
    logic [2:0][15:0]       dly_vec;
    logic                   tick;
    logic [15:0]            thr_ov_on;
    logic [15:0]            thr_ov_off;
    logic [15:0]            thr_uv_on;
    logic [15:0]            thr_uv_off;
    logic [15:0]            thr_uv_blk;
    logic [15:0]            thr_rov_on;
    logic [15:0]            thr_rov_off;

    // percent setting times a percent factor gives hundredths of a percent
    function automatic logic [15:0] vps_scale(input logic [7:0] pick, input logic [7:0] pct);
        vps_scale = {8'h00, pick} * {8'h00, pct};
    endfunction

    function automatic logic [1:0] vps_count3(input logic [2:0] bits);
        vps_count3 = {1'b0, bits[0]} + {1'b0, bits[1]} + {1'b0, bits[2]};
    endfunction

    assign v_ph = {phase_voltage_c, phase_voltage_b, phase_voltage_a};

    // thresholds only depend on settings; no divider needed
    assign thr_ov_on   = vps_scale(s_r.ov_pick, VPS_PCT_UNIT);
    assign thr_ov_off  = vps_scale(s_r.ov_pick, VPS_PCT_UNIT - {4'h0, s_r.ov_rr});
    assign thr_uv_on   = vps_scale(s_r.uv_pick, VPS_PCT_UNIT);
    assign thr_uv_off  = vps_scale(s_r.uv_pick, VPS_PCT_UNIT + {4'h0, s_r.uv_rr});
    assign thr_uv_blk  = vps_scale({3'h0, s_r.uv_blk}, VPS_PCT_UNIT);
    assign thr_rov_on  = vps_scale(s_r.rov_pick, VPS_PCT_UNIT);
    assign thr_rov_off = vps_scale(s_r.rov_pick, VPS_PCT_UNIT - {4'h0, s_r.rov_rr});

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 32'h0000_0000;

        if (reg_wr) begin
            case (reg_addr)
                VPS_REG_CTRL: begin
                    s_nxt.ov_on   = reg_wdata[VPS_CTRL_OV_ON];
                    s_nxt.rov_on  = reg_wdata[VPS_CTRL_ROV_ON];
                    s_nxt.uv_mode = vps_uv_mode_e'(reg_wdata[VPS_CTRL_UV_MODE +: 2]);
                    s_nxt.ov_so   = reg_wdata[VPS_CTRL_OV_SO];
                    s_nxt.uv_so   = reg_wdata[VPS_CTRL_UV_SO];
                    s_nxt.rov_so  = reg_wdata[VPS_CTRL_ROV_SO];
                end
                VPS_REG_OV_CFG: begin
                    s_nxt.ov_pick = reg_wdata[VPS_CFG_PICK +: 8];
                    s_nxt.ov_rr   = reg_wdata[VPS_CFG_RR +: 4];
                end
                VPS_REG_UV_CFG: begin
                    s_nxt.uv_pick = reg_wdata[VPS_CFG_PICK +: 8];
                    s_nxt.uv_rr   = reg_wdata[VPS_CFG_RR +: 4];
                    s_nxt.uv_blk  = reg_wdata[VPS_CFG_BLK +: 5];
                end
                VPS_REG_ROV_CFG: begin
                    s_nxt.rov_pick = reg_wdata[VPS_CFG_PICK +: 8];
                    s_nxt.rov_rr   = reg_wdata[VPS_CFG_RR +: 4];
                end
                VPS_REG_OV_DELAY: begin
                    s_nxt.ov_dly = reg_wdata[15:0];
                end
                VPS_REG_UV_DELAY: begin
                    s_nxt.uv_dly = reg_wdata[15:0];
                end
                VPS_REG_ROV_DELAY: begin
                    s_nxt.rov_dly = reg_wdata[15:0];
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                VPS_REG_CTRL: begin
                    s_nxt.rdata = {25'h0, s_r.rov_so, s_r.uv_so, s_r.ov_so, s_r.uv_mode, s_r.rov_on, s_r.ov_on};
                end
                VPS_REG_OV_CFG: begin
                    s_nxt.rdata = {20'h0, s_r.ov_rr, s_r.ov_pick};
                end
                VPS_REG_UV_CFG: begin
                    s_nxt.rdata = {11'h0, s_r.uv_blk, 4'h0, s_r.uv_rr, s_r.uv_pick};
                end
                VPS_REG_ROV_CFG: begin
                    s_nxt.rdata = {20'h0, s_r.rov_rr, s_r.rov_pick};
                end
                VPS_REG_OV_DELAY: begin
                    s_nxt.rdata = {16'h0, s_r.ov_dly};
                end
                VPS_REG_UV_DELAY: begin
                    s_nxt.rdata = {16'h0, s_r.uv_dly};
                end
                VPS_REG_ROV_DELAY: begin
                    s_nxt.rdata = {16'h0, s_r.rov_dly};
                end
                VPS_REG_STATUS: begin
                    s_nxt.rdata = {20'h0, trip_vec[2], s_r.rov_st, trip_vec[1], s_r.uv_any, s_r.uv_st,
                                   trip_vec[0], s_r.ov_any, s_r.ov_st};
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        for (int i = 0; i < 3; i++) begin
            // hysteresis keeps a start alive until the reset margin is crossed
            if (!s_r.ov_on) begin
                s_nxt.ov_st[i] = 1'b0;
            end else if (s_r.ov_st[i]) begin
                s_nxt.ov_st[i] = v_ph[i] >= thr_ov_off;
            end else begin
                s_nxt.ov_st[i] = v_ph[i] > thr_ov_on;
            end

            if ((s_r.uv_mode == VPS_UV_OFF) || (v_ph[i] <= thr_uv_blk)) begin
                s_nxt.uv_st[i] = 1'b0;
            end else if (s_r.uv_st[i]) begin
                s_nxt.uv_st[i] = v_ph[i] <= thr_uv_off;
            end else begin
                s_nxt.uv_st[i] = v_ph[i] < thr_uv_on;
            end
        end

        s_nxt.ov_any = |s_nxt.ov_st;

        case (s_r.uv_mode)
            VPS_UV_1OF3: begin
                s_nxt.uv_any = vps_count3(s_nxt.uv_st) >= 2'h1;
            end
            VPS_UV_2OF3: begin
                s_nxt.uv_any = vps_count3(s_nxt.uv_st) >= 2'h2;
            end
            VPS_UV_ALL: begin
                s_nxt.uv_any = vps_count3(s_nxt.uv_st) == 2'h3;
            end
            default: begin
                s_nxt.uv_any = 1'b0;
            end
        endcase

        // residual input is already the fundamental RMS of three times zero sequence
        if (!s_r.rov_on) begin
            s_nxt.rov_st = 1'b0;
        end else if (s_r.rov_st) begin
            s_nxt.rov_st = residual_voltage_magnitude >= thr_rov_off;
        end else begin
            s_nxt.rov_st = residual_voltage_magnitude > thr_rov_on;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    vps_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );

    assign arm_vec = {s_r.rov_st, s_r.uv_any, s_r.ov_any};
    assign so_vec  = {s_r.rov_so, s_r.uv_so, s_r.ov_so};
    assign dly_vec = {s_r.rov_dly, s_r.uv_dly, s_r.ov_dly};

    // one definite-time timer per stage, shared ms tick
    for (genvar g = 0; g < 3; g++) begin : g_stage
        vps_delay u_delay (
            .clk        (clk),
            .rstn       (rstn),
            .tick       (tick),
            .start      (arm_vec[g]),
            .start_only (so_vec[g]),
            .delay      (dly_vec[g]),
            .trip       (trip_vec[g])
        );
    end

    assign reg_rdata    = s_r.rdata;
    assign ov_start     = s_r.ov_st;
    assign ov_start_any = s_r.ov_any;
    assign ov_trip      = trip_vec[0];
    assign uv_start     = s_r.uv_st;
    assign uv_start_any = s_r.uv_any;
    assign uv_trip      = trip_vec[1];
    assign res_ov_start = s_r.rov_st;
    assign res_ov_trip  = trip_vec[2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_ov_off2;
        !s_r.ov_on [*2];
    endsequence

    sequence s_rov_off2;
        !s_r.rov_on [*2];
    endsequence

    a_ov_phase_set: assert property (
        s_r.ov_on && !s_r.ov_st[0] && (v_ph[0] > thr_ov_on) |=> ov_start[0])
        else $error("phase a overvoltage start missing");
    a_ov_general_or: assert property (ov_start_any == (|ov_start))
        else $error("overvoltage general start is not the OR of phases");
    a_ov_off_quiet: assert property (s_ov_off2 |=> (ov_start == 3'h0) && !ov_trip)
        else $error("overvoltage stage active while off");
    a_ov_hold: assert property (s_r.ov_on && ov_start[1] && (v_ph[1] >= thr_ov_off) |=> ov_start[1])
        else $error("overvoltage start dropped inside reset margin");
    a_uv_block: assert property ((v_ph[2] <= thr_uv_blk) |=> !uv_start[2])
        else $error("undervoltage start below blocking level");
    a_uv_release: assert property (uv_start[0] && (v_ph[0] > thr_uv_off) |=> !uv_start[0])
        else $error("undervoltage start kept above reset margin");
    a_uv_all_mode: assert property (
        ($past(s_r.uv_mode) == VPS_UV_ALL) && (uv_start != 3'h7) |-> !uv_start_any)
        else $error("all-phase mode started with a phase healthy");
    a_uv_two_mode: assert property (
        ($past(s_r.uv_mode) == VPS_UV_2OF3) && (vps_count3(uv_start) < 2'h2) |-> !uv_start_any)
        else $error("two-phase mode started with one phase low");
    a_uv_one_mode: assert property (
        ($past(s_r.uv_mode) == VPS_UV_1OF3) |-> uv_start_any == (|uv_start))
        else $error("one-phase mode general start is not the OR of phases");
    a_uv_off_quiet: assert property (
        (s_r.uv_mode == VPS_UV_OFF) |=> !uv_start_any && (uv_start == 3'h0))
        else $error("undervoltage stage active while off");
    a_uv_phase_set: assert property (
        (s_r.uv_mode != VPS_UV_OFF) && !uv_start[1] && (v_ph[1] < thr_uv_on) && (v_ph[1] > thr_uv_blk)
        |=> uv_start[1])
        else $error("undervoltage phase start missing");
    a_ov_release: assert property (ov_start[2] && (v_ph[2] < thr_ov_off) |=> !ov_start[2])
        else $error("overvoltage start kept below reset margin");
    a_rov_start_set: assert property (
        s_r.rov_on && !s_r.rov_st && (residual_voltage_magnitude > thr_rov_on) |=> res_ov_start)
        else $error("residual start missing above pick-up");
    a_rov_hold: assert property (
        s_r.rov_on && res_ov_start && (residual_voltage_magnitude >= thr_rov_off) |=> res_ov_start)
        else $error("residual start dropped inside reset margin");
    a_rov_release: assert property (
        res_ov_start && (residual_voltage_magnitude < thr_rov_off) |=> !res_ov_start)
        else $error("residual start kept below reset margin");
    a_rov_off_quiet: assert property (s_rov_off2 |=> !res_ov_start && !res_ov_trip)
        else $error("residual stage active while off");
    a_rd_one_cycle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside the read answer cycle");

endmodule

`default_nettype wire

// File: bench/test_voltage_protection_stages.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

module test_voltage_protection_stages;
    import vps_pkg::*;

    localparam int tc      = 4;
    localparam int dly     = 3;
    // ov pick raised to 110 so a nominal 100 percent phase stays quiet for both phase stages
    localparam int ov_pick = 110;
    localparam int rr      = int'(VPS_RR_RST);
    localparam int pu      = int'(VPS_PCT_UNIT);
    localparam int ov_thr  = ov_pick * pu;
    localparam int ov_rel  = ov_pick * (pu - rr);
    localparam int uv_thr  = int'(VPS_UV_PICK_RST) * pu;
    localparam int uv_rel  = int'(VPS_UV_PICK_RST) * (pu + rr);
    localparam int blk_lvl = int'(VPS_UV_BLK_RST) * pu;
    localparam int rov_thr = int'(VPS_ROV_PICK_RST) * pu;
    localparam int rov_rel = int'(VPS_ROV_PICK_RST) * (pu - rr);
    localparam int nom     = pu * pu;

    logic              clk;
    logic              rstn;
    logic [VPS_AW-1:0] reg_addr;
    logic [VPS_DW-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [VPS_DW-1:0] reg_rdata;
    logic [VPS_VW-1:0] va, vb, vc, vr;
    logic [2:0]        ov_start, uv_start;
    logic              ov_start_any, ov_trip, uv_start_any, uv_trip, res_ov_start, res_ov_trip;
    int                num_errors;
    int                checks_done;
    int                cycles = 0;

    vps_top #(.TICK_CYCLES(tc)) dut (
        .clk                        (clk),
        .rstn                       (rstn),
        .reg_addr                   (reg_addr),
        .reg_wdata                  (reg_wdata),
        .reg_wr                     (reg_wr),
        .reg_rd                     (reg_rd),
        .reg_rdata                  (reg_rdata),
        .phase_voltage_a            (va),
        .phase_voltage_b            (vb),
        .phase_voltage_c            (vc),
        .residual_voltage_magnitude (vr),
        .ov_start                   (ov_start),
        .ov_start_any               (ov_start_any),
        .ov_trip                    (ov_trip),
        .uv_start                   (uv_start),
        .uv_start_any               (uv_start_any),
        .uv_trip                    (uv_trip),
        .res_ov_start               (res_ov_start),
        .res_ov_trip                (res_ov_trip)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard, generous against the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end

    function automatic logic [31:0] cfg(input int pick, input int r, input int b);
        return (32'(b) << VPS_CFG_BLK) | (32'(r) << VPS_CFG_RR) | 32'(pick);
    endfunction

    function automatic logic trip_of(input int sel);
        case (sel)
            0: return ov_trip;
            1: return uv_trip;
            default: return res_ov_trip;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic drv(input int a, input int b, input int c, input int r);
        @(posedge clk);
        va <= 16'(a);
        vb <= 16'(b);
        vc <= 16'(c);
        vr <= 16'(r);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // cycles from the call to trip; the first ms tick is free running, so one tick of slack
    task automatic meas(input int sel, input int d);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (trip_of(sel) !== 1'b1 && n < 200);
        `CHK((n >= (d - 1) * tc) && (n <= d * tc + 6), 1'b1)
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [7:0]  adr [8] = '{VPS_REG_CTRL, VPS_REG_OV_CFG, VPS_REG_UV_CFG, VPS_REG_ROV_CFG,
                                 VPS_REG_OV_DELAY, VPS_REG_UV_DELAY, VPS_REG_ROV_DELAY, 8'h20};
        logic [31:0] exp [8];
        exp = '{32'h00000007, cfg(int'(VPS_OV_PICK_RST), rr, 0),
                cfg(int'(VPS_UV_PICK_RST), rr, int'(VPS_UV_BLK_RST)), cfg(int'(VPS_ROV_PICK_RST), rr, 0),
                32'(VPS_DELAY_RST), 32'(VPS_DELAY_RST), 32'(VPS_DELAY_RST), 32'h00000000};
        for (int i = 0; i < 8; i++) begin
            rd(adr[i], d);
            `CHK(d, exp[i])
        end
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, d);
        `CHK(d, 32'h00000000)
        wr(VPS_REG_OV_CFG, cfg(ov_pick, rr, 0));
        wr(VPS_REG_OV_DELAY, 32'(dly));
        wr(VPS_REG_UV_DELAY, 32'(dly));
        wr(VPS_REG_ROV_DELAY, 32'(dly));
        rd(VPS_REG_OV_CFG, d);
        `CHK(d, cfg(ov_pick, rr, 0))
        $display("test regs done");
    endtask

    task automatic t_ov();
        logic [31:0] d;
        drv(ov_thr, ov_thr + 1, nom, 0);
        settle();
        `CHK(ov_start, 3'b010)
        `CHK(ov_start_any, 1'b1)
        `CHK(ov_trip, 1'b0)
        meas(0, dly);
        rd(VPS_REG_STATUS, d);
        `CHK(d, 32'h0000001A)
        drv(nom, ov_rel, nom, 0);
        settle();
        `CHK(ov_start_any, 1'b1)
        drv(nom, ov_rel - 1, nom, 0);
        @(posedge clk);
        #1;
        `CHK({ov_start_any, ov_trip}, 2'b01)
        @(posedge clk);
        #1;
        `CHK(ov_trip, 1'b0)
        $display("test ov done");
    endtask

    task automatic t_only_off();
        wr(VPS_REG_CTRL, 32'h00000017);
        drv(ov_thr + 1, nom, nom, 0);
        repeat ((dly + 2) * tc) @(posedge clk);
        #1;
        `CHK({ov_start_any, ov_trip}, 2'b10)
        wr(VPS_REG_CTRL, 32'h00000007);
        settle();
        `CHK(ov_trip, 1'b1)
        wr(VPS_REG_CTRL, 32'h00000004);
        drv(ov_thr + 1, nom, nom, rov_thr + 1);
        settle();
        `CHK({ov_start, ov_start_any, ov_trip, res_ov_start, res_ov_trip}, 7'h00)
        wr(VPS_REG_CTRL, 32'h00000007);
        drv(nom, nom, nom, 0);
        settle();
        $display("test only_off done");
    endtask

    task automatic t_uv();
        logic [1:0] any_exp [4] = '{2'h0, 2'h1, 2'h1, 2'h0};
        for (int m = 0; m < 4; m++) begin
            wr(VPS_REG_CTRL, 32'(m << VPS_CTRL_UV_MODE) | 32'h00000003);
            drv(uv_thr - 1, uv_thr - 1000, blk_lvl, 0);
            settle();
            `CHK(uv_start, (m == 0) ? 3'b000 : 3'b011)
            `CHK(uv_start_any, any_exp[m][0])
        end
        drv(uv_thr - 1, uv_thr - 1000, blk_lvl + 1, 0);
        settle();
        `CHK({uv_start, uv_start_any}, 4'b1111)
        // one low phase must not start the two-phase mode
        wr(VPS_REG_CTRL, 32'h0000000B);
        drv(uv_thr - 1, nom, nom, 0);
        settle();
        `CHK({uv_start, uv_start_any}, 4'b0010)
        drv(nom, nom, nom, 0);
        wr(VPS_REG_CTRL, 32'h00000007);
        settle();
        `CHK({uv_start_any, uv_trip}, 2'b00)
        drv(uv_thr, nom, uv_thr - 1, 0);
        settle();
        `CHK(uv_start, 3'b100)
        meas(1, dly);
        drv(nom, nom, uv_rel, 0);
        settle();
        `CHK(uv_start_any, 1'b1)
        drv(nom, nom, uv_rel + 1, 0);
        settle();
        `CHK({uv_start, uv_start_any, uv_trip}, 5'h00)
        $display("test uv done");
    endtask

    task automatic t_rov();
        // start only on the undervoltage and residual stages
        wr(VPS_REG_CTRL, 32'h00000067);
        drv(uv_thr - 1, nom, nom, rov_thr + 1);
        repeat ((dly + 2) * tc) @(posedge clk);
        #1;
        `CHK({uv_start_any, uv_trip, res_ov_start, res_ov_trip}, 4'b1010)
        drv(nom, nom, nom, 0);
        wr(VPS_REG_CTRL, 32'h00000007);
        drv(nom, nom, nom, rov_thr);
        settle();
        `CHK(res_ov_start, 1'b0)
        drv(nom, nom, nom, rov_thr + 1);
        settle();
        `CHK({res_ov_start, ov_start_any}, 2'b10)
        meas(2, dly);
        drv(nom, nom, nom, rov_rel);
        settle();
        `CHK(res_ov_start, 1'b1)
        drv(nom, nom, nom, rov_rel - 1);
        settle();
        `CHK({res_ov_start, res_ov_trip}, 2'b00)
        $display("test rov done");
    endtask

    initial begin
        num_errors = 0;
        checks_done = 0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        va = 16'(nom);
        vb = 16'(nom);
        vc = 16'(nom);
        vr = 16'h0000;
        repeat (3) @(posedge clk);
        #1;
        `CHK({ov_start_any, uv_start_any, res_ov_start}, 3'b000)
        @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        settle();
        t_ov();
        t_only_off();
        t_uv();
        t_rov();
        close_out();
    end

endmodule

`default_nettype wire
